// ===== logic/sfp_map.svh
// Offsets, field positions, reset values and timing counts of the serial flash frame link
`ifndef SFP_MAP_SVH
`define SFP_MAP_SVH

`define SFP_CLK_MHZ 125
`define SFP_SELECT_DELAY_US 70
`define SFP_PROGRAM_DELAY_MS 3
`define SFP_SELECT_DELAY_CYC (`SFP_SELECT_DELAY_US * `SFP_CLK_MHZ)
`define SFP_PROGRAM_DELAY_CYC (`SFP_PROGRAM_DELAY_MS * 1000 * `SFP_CLK_MHZ)
`define SFP_SCK_HALF 4'd10
`define SFP_MODE_RESET 1'b1
`define SFP_OPC_LAST 6'd7
`define SFP_ADDR_LAST 6'd23
`define SFP_PAGE_MSB 19
`define SFP_PAGE_LSB 9
`define SFP_OFFSET_MSB 8
`define SFP_OP_LONG_DUMMY 8'hd2
`define SFP_OP_SHORT_DUMMY_A 8'hd4
`define SFP_OP_SHORT_DUMMY_B 8'hd6
`define SFP_DUMMY_LONG 3'd4
`define SFP_DUMMY_SHORT 3'd1
`define SFP_DUMMY_NONE 3'd0
`define SFP_LEAD_DUMMY 4'h0
`define SFP_HDR_BITS 8'd32
`define SFP_FIFO_DEPTH 4

`endif

// ===== logic/sfp_pkg.sv
// Types shared by both ends of the serial flash frame link
`default_nettype none
`include "sfp_map.svh"
package sfp_pkg;

  typedef enum logic [2:0] {
    SFP_D_IDLE = 3'b000,
    SFP_D_OPC = 3'b001,
    SFP_D_ADDR = 3'b010,
    SFP_D_DUMMY = 3'b011,
    SFP_D_DATA = 3'b100
  } sfp_dev_state_t;

  typedef enum logic [2:0] {
    SFP_H_IDLE = 3'b000,
    SFP_H_SEL = 3'b001,
    SFP_H_RUN = 3'b010,
    SFP_H_END = 3'b011,
    SFP_H_GAP = 3'b100
  } sfp_host_state_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [10:0] page;
    logic [8:0] offset;
  } sfp_frame_t;

  // Extra dummy bytes that follow the three address bytes
  function automatic logic [2:0] sfp_dummy_bytes(input logic [7:0] opc);
    case (opc)
      `SFP_OP_LONG_DUMMY: sfp_dummy_bytes = `SFP_DUMMY_LONG;
      `SFP_OP_SHORT_DUMMY_A: sfp_dummy_bytes = `SFP_DUMMY_SHORT;
      `SFP_OP_SHORT_DUMMY_B: sfp_dummy_bytes = `SFP_DUMMY_SHORT;
      default: sfp_dummy_bytes = `SFP_DUMMY_NONE;
    endcase
  endfunction

endpackage
`default_nettype wire

// ===== logic/sfp_link_if.sv
// Serial link between the flash host and the flash device
`timescale 1ns/1ps
`default_nettype none
interface sfp_link_if;
  logic cs_n;
  logic sck;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  logic miso;

  // Undriven data line reads low
  assign miso = miso_oe & miso_o;

  modport host (output cs_n, output sck, output mosi, input miso);
  modport device (input cs_n, input sck, input mosi, output miso_o, output miso_oe);
endinterface
`default_nettype wire

// ===== logic/sfp_device.sv
// Flash device end: frame decoder, mode select, read data driver and frame FIFO
//
// Overview of operation
// - Mode 3 after power-up or reset
// - Data output undriven until read data
// - Instruction starts only on select falling
// - Mode sampled from clock idle level
// - Host waits 70 us before selecting
// - Commands ignored while power-on reset active, except a frame whose header ends in the first active cycle
// - Standby and ready after power-up
// - First command waits up to 3 ms if it programs
// - Address: 4 dummy, 11 page, 9 byte
`timescale 1ns/1ps
`default_nettype none
`include "sfp_map.svh"

module sfp_fifo #(
  parameter int WIDTH = 28,
  parameter int DEPTH = `SFP_FIFO_DEPTH
) (
  input wire logic sys_clk, // System clock
  input wire logic sys_rst, // Asynchronous reset
  input wire logic in_valid, // Write request
  output logic in_ready, // Room for a word
  input wire logic [WIDTH-1:0] in_data, // Write data
  output logic out_valid, // Word available
  input wire logic out_ready, // Drain accepts word
  output logic [WIDTH-1:0] out_data // Head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;

  // Depth must be a power of two for the wrap bit to work
  assign in_ready = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge sys_clk) begin
    if (in_valid && in_ready) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr <= '0;
    end else if (in_valid && in_ready) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_ptr <= '0;
    end else if (out_valid && out_ready) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule // sfp_fifo

module sfp_device (
  input wire logic sys_clk, // System clock
  input wire logic sys_rst, // Asynchronous reset
  sfp_link_if.device link, // Serial link to the host
  input wire logic por_active, // Internal power-on reset level
  input wire logic [7:0] tx_byte, // Read data to send
  output logic tx_taken, // Pulse: tx_byte loaded
  output logic frame_valid, // Decoded frame available
  input wire logic frame_ready, // Frame consumer accepts
  output sfp_pkg::sfp_frame_t frame, // Decoded opcode and address
  output logic spi_mode3, // Current mode: 1 = mode 3, 0 = mode 0
  output logic standby // Idle and ready
);
  import sfp_pkg::*;

  logic cs_q1, cs_q2, cs_q3;
  logic sck_q1, sck_q2, sck_q3;
  logic mosi_q1, mosi_q2;
  sfp_dev_state_t state;
  logic [5:0] bit_cnt;
  logic [5:0] dummy_left;
  logic [7:0] opc;
  logic [23:0] addr_sh;
  logic [23:0] hdr_addr;
  logic [2:0] tx_cnt;
  logic [6:0] tx_sh;
  logic miso_r;
  logic miso_oe_r;
  logic fifo_in_ready;
  logic hdr_done;
  logic quiet;
  sfp_frame_t frame_in;

  // Two-stage synchronisers, third stage only for edge detection
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cs_q1 <= 1'b1;
      cs_q2 <= 1'b1;
      cs_q3 <= 1'b1;
      sck_q1 <= `SFP_MODE_RESET;
      sck_q2 <= `SFP_MODE_RESET;
      sck_q3 <= `SFP_MODE_RESET;
      mosi_q1 <= 1'b0;
      mosi_q2 <= 1'b0;
    end else begin
      cs_q1 <= link.cs_n;
      cs_q2 <= cs_q1;
      cs_q3 <= cs_q2;
      sck_q1 <= link.sck;
      sck_q2 <= sck_q1;
      sck_q3 <= sck_q2;
      mosi_q1 <= link.mosi;
      mosi_q2 <= mosi_q1;
    end
  end

  wire cs_fall = cs_q3 & ~cs_q2;
  wire sck_rise = ~sck_q3 & sck_q2;
  wire sck_fall = sck_q3 & ~sck_q2;

  assign quiet = por_active | cs_q2;
  assign hdr_addr = (state == SFP_D_ADDR) ? {addr_sh[22:0], mosi_q2} : addr_sh;
  assign hdr_done = sck_rise && (((state == SFP_D_ADDR) && (bit_cnt == `SFP_ADDR_LAST)
                    && (sfp_dummy_bytes(opc) == `SFP_DUMMY_NONE))
                    || ((state == SFP_D_DUMMY) && (dummy_left == 6'd1)));
  assign frame_in.opcode = opc;
  assign frame_in.page = hdr_addr[`SFP_PAGE_MSB:`SFP_PAGE_LSB];
  assign frame_in.offset = hdr_addr[`SFP_OFFSET_MSB:0];

  // Frame decoder
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= SFP_D_IDLE;
      bit_cnt <= 6'd0;
      dummy_left <= 6'd0;
      opc <= 8'h00;
      addr_sh <= 24'h000000;
    end else if (quiet) begin
      state <= SFP_D_IDLE;
      bit_cnt <= 6'd0;
    end else begin
      case (state)
        SFP_D_IDLE: begin
          // A full FIFO refuses the frame
          if (cs_fall && fifo_in_ready) begin
            state <= SFP_D_OPC;
            bit_cnt <= 6'd0;
          end
        end
        SFP_D_OPC: begin
          if (sck_rise) begin
            opc <= {opc[6:0], mosi_q2};
            bit_cnt <= bit_cnt + 6'd1;
            if (bit_cnt == `SFP_OPC_LAST) begin
              state <= SFP_D_ADDR;
              bit_cnt <= 6'd0;
            end
          end
        end
        SFP_D_ADDR: begin
          if (sck_rise) begin
            addr_sh <= hdr_addr;
            bit_cnt <= bit_cnt + 6'd1;
            if (bit_cnt == `SFP_ADDR_LAST) begin
              dummy_left <= {sfp_dummy_bytes(opc), 3'b000};
              state <= (sfp_dummy_bytes(opc) == `SFP_DUMMY_NONE) ? SFP_D_DATA : SFP_D_DUMMY;
            end
          end
        end
        SFP_D_DUMMY: begin
          if (sck_rise) begin
            dummy_left <= dummy_left - 6'd1;
            if (dummy_left == 6'd1) begin
              state <= SFP_D_DATA;
            end
          end
        end
        SFP_D_DATA: begin
          state <= SFP_D_DATA;
        end
        default: begin
          state <= SFP_D_IDLE;
        end
      endcase
    end
  end

  // Read data driver, shifts on falling clock edges
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      miso_r <= 1'b0;
      miso_oe_r <= 1'b0;
      tx_cnt <= 3'd0;
      tx_sh <= 7'h00;
      tx_taken <= 1'b0;
    end else if (quiet) begin
      miso_r <= 1'b0;
      miso_oe_r <= 1'b0;
      tx_cnt <= 3'd0;
      tx_taken <= 1'b0;
    end else if ((state == SFP_D_DATA) && sck_fall) begin
      miso_oe_r <= 1'b1;
      tx_cnt <= tx_cnt + 3'd1;
      tx_taken <= (tx_cnt == 3'd0);
      if (tx_cnt == 3'd0) begin
        miso_r <= tx_byte[7];
        tx_sh <= tx_byte[6:0];
      end else begin
        miso_r <= tx_sh[6];
        tx_sh <= {tx_sh[5:0], 1'b0};
      end
    end else begin
      tx_taken <= 1'b0;
    end
  end

  // Mode select from the clock idle level at select fall
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      spi_mode3 <= `SFP_MODE_RESET;
    end else if (por_active) begin
      spi_mode3 <= `SFP_MODE_RESET;
    end else if (cs_fall) begin
      spi_mode3 <= sck_q2;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      standby <= 1'b0;
    end else begin
      standby <= ~por_active & (state == SFP_D_IDLE);
    end
  end

  assign link.miso_o = miso_r;
  assign link.miso_oe = miso_oe_r;

  sfp_fifo #(
    .WIDTH($bits(sfp_frame_t)),
    .DEPTH(`SFP_FIFO_DEPTH)
  ) u_frame_fifo (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .in_valid(hdr_done),
    .in_ready(fifo_in_ready),
    .in_data(frame_in),
    .out_valid(frame_valid),
    .out_ready(frame_ready),
    .out_data(frame)
  );
endmodule // sfp_device
`default_nettype wire

// ===== logic/sfp_host.sv
// Flash host end: power-up wait, clock divider and frame sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sfp_map.svh"

module sfp_host #(
  parameter int SELECT_DELAY_CYC = `SFP_SELECT_DELAY_CYC,
  parameter int PROGRAM_DELAY_CYC = `SFP_PROGRAM_DELAY_CYC
) (
  input wire logic sys_clk, // System clock
  input wire logic sys_rst, // Asynchronous reset, taken as power-up
  sfp_link_if.host link, // Serial link to the device
  input wire logic mode3, // Clock idles high when set
  input wire logic cmd_valid, // Command request
  output logic cmd_ready, // Command accepted when valid
  input wire logic [7:0] cmd_opcode, // Opcode
  input wire logic [10:0] cmd_page, // Page address
  input wire logic [8:0] cmd_offset, // Byte or buffer address
  input wire logic cmd_program, // Command programs or erases
  input wire logic [3:0] cmd_read_len, // Bytes to read after header
  output logic rsp_valid, // Pulse: read byte ready
  output logic [7:0] rsp_data, // Read byte
  output logic access_ok // Select delay has elapsed
);
  import sfp_pkg::*;

  logic [19:0] pwr_cnt;
  logic prog_ok;
  logic first_done;
  sfp_host_state_t st;
  logic [3:0] div;
  logic sck_r;
  logic cs_r;
  logic idle_lvl;
  logic sampled;
  logic [63:0] tx_sh;
  logic [7:0] tot;
  logic [7:0] hdr;
  logic [7:0] rise_cnt;
  logic miso_q1, miso_q2;
  logic [2:0] rx_bits;
  logic [6:0] rx_sh;
  logic tick;
  logic rise_now;
  logic accept;

  // Power-up timers, saturating at the longer wait
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pwr_cnt <= 20'd0;
      access_ok <= 1'b0;
      prog_ok <= 1'b0;
    end else begin
      if (!prog_ok) begin
        pwr_cnt <= pwr_cnt + 20'd1;
      end
      access_ok <= access_ok | (pwr_cnt >= 20'(SELECT_DELAY_CYC));
      prog_ok <= prog_ok | (pwr_cnt >= 20'(PROGRAM_DELAY_CYC));
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      first_done <= 1'b0;
    end else if (accept) begin
      first_done <= 1'b1;
    end
  end

  assign cmd_ready = (st == SFP_H_IDLE) && access_ok
                     && (prog_ok || first_done || !cmd_program);
  assign accept = cmd_valid & cmd_ready;
  assign tick = (div == `SFP_SCK_HALF - 4'd1);
  assign rise_now = (st == SFP_H_RUN) && tick && !sck_r;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      div <= 4'd0;
    end else if ((st == SFP_H_IDLE) || tick) begin
      div <= 4'd0;
    end else begin
      div <= div + 4'd1;
    end
  end

  // Frame sequencer: select, clock edges, release
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= SFP_H_IDLE;
      cs_r <= 1'b1;
      sck_r <= `SFP_MODE_RESET;
      idle_lvl <= `SFP_MODE_RESET;
      sampled <= 1'b0;
      tx_sh <= 64'h0;
      tot <= 8'd0;
      hdr <= 8'd0;
      rise_cnt <= 8'd0;
    end else begin
      case (st)
        SFP_H_IDLE: begin
          cs_r <= 1'b1;
          sck_r <= mode3;
          idle_lvl <= mode3;
          if (accept) begin
            st <= SFP_H_SEL;
            cs_r <= 1'b0;
            sampled <= 1'b0;
            rise_cnt <= 8'd0;
            tx_sh <= {cmd_opcode, `SFP_LEAD_DUMMY, cmd_page, cmd_offset, 32'h0};
            hdr <= `SFP_HDR_BITS + {2'b00, sfp_dummy_bytes(cmd_opcode), 3'b000};
            tot <= `SFP_HDR_BITS + {2'b00, sfp_dummy_bytes(cmd_opcode), 3'b000}
                   + {1'b0, cmd_read_len, 3'b000};
          end
        end
        SFP_H_SEL: begin
          if (tick) begin
            st <= SFP_H_RUN;
          end
        end
        SFP_H_RUN: begin
          if (tick) begin
            if (!sck_r) begin
              sck_r <= 1'b1;
              sampled <= 1'b1;
              rise_cnt <= rise_cnt + 8'd1;
              if (rise_cnt == tot - 8'd1) begin
                st <= SFP_H_END;
              end
            end else begin
              sck_r <= 1'b0;
              if (sampled) begin
                tx_sh <= {tx_sh[62:0], 1'b0};
              end
            end
          end
        end
        SFP_H_END: begin
          if (tick) begin
            if (sck_r != idle_lvl) begin
              sck_r <= idle_lvl;
            end else begin
              cs_r <= 1'b1;
              st <= SFP_H_GAP;
            end
          end
        end
        SFP_H_GAP: begin
          if (tick) begin
            st <= SFP_H_IDLE;
          end
        end
        default: begin
          st <= SFP_H_IDLE;
        end
      endcase
    end
  end

  // Read data capture on rising edges past the header
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      miso_q1 <= 1'b0;
      miso_q2 <= 1'b0;
      rx_bits <= 3'd0;
      rx_sh <= 7'h00;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
    end else begin
      miso_q1 <= link.miso;
      miso_q2 <= miso_q1;
      rsp_valid <= 1'b0;
      if (st == SFP_H_IDLE) begin
        rx_bits <= 3'd0;
      end else if (rise_now && (rise_cnt >= hdr)) begin
        rx_bits <= rx_bits + 3'd1;
        rx_sh <= {rx_sh[5:0], miso_q2};
        if (rx_bits == 3'd7) begin
          rsp_valid <= 1'b1;
          rsp_data <= {rx_sh, miso_q2};
        end
      end
    end
  end

  assign link.cs_n = cs_r;
  assign link.sck = sck_r;
  assign link.mosi = tx_sh[63];
endmodule // sfp_host
`default_nettype wire

// ===== bench/sfp_link_chk.sv
// Assertions on the serial link between flash host and flash device
`timescale 1ns/1ps
`default_nettype none
module sfp_link_chk (
  input wire logic sys_clk, // System clock
  input wire logic sys_rst, // Asynchronous reset
  input wire logic cs_n, // Select, active low
  input wire logic sck, // Serial clock
  input wire logic mosi, // Host data
  input wire logic miso_o, // Device data
  input wire logic miso_oe, // Device drive enable
  input wire logic miso // Resolved device data
);
  logic sck_q;
  logic [7:0] n_rise;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) sck_q <= 1'b1;
    else sck_q <= sck;
  end
  // Rising clock edges within the current frame
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) n_rise <= 8'h00;
    else if (cs_n) n_rise <= 8'h00;
    else if (sck && !sck_q) n_rise <= n_rise + 8'h01;
  end
  sequence s_sel; $fell(cs_n); endsequence
  sequence s_edge; !cs_n && $changed(sck); endsequence
  property p_reset_idle; $fell(sys_rst) |-> cs_n && sck && !miso_oe; endproperty
  property p_sel_quiet; s_sel |-> ($stable(sck) && !miso_oe) [*8]; endproperty
  property p_half; s_edge |=> $stable(sck) [*8]; endproperty
  property p_oe_release; cs_n [*4] |-> !miso_oe; endproperty
  property p_oe_select; miso_oe |-> !$past(cs_n, 4); endproperty
  property p_oe_rise; $rose(miso_oe) |-> !sck && !cs_n; endproperty
  property p_drive_low; miso_oe && $past(miso_oe) && $changed(miso_o) |-> !sck; endproperty
  property p_mosi_hold; $rose(sck) && !cs_n |-> $stable(mosi) [*4]; endproperty
  property p_frame_bits; $rose(cs_n) |-> n_rise >= 8'd32 && n_rise[2:0] == 3'h0; endproperty
  property p_oe_header; miso_oe && !cs_n |-> n_rise >= 8'd32; endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("link busy after reset");
  a_sel_quiet: assert property (p_sel_quiet) else $error("clock moved at select");
  a_half: assert property (p_half) else $error("clock half period short");
  a_oe_release: assert property (p_oe_release) else $error("data driven unselected");
  a_oe_select: assert property (p_oe_select) else $error("drive without select");
  a_oe_rise: assert property (p_oe_rise) else $error("drive began off falling edge");
  a_drive_low: assert property (p_drive_low) else $error("data changed with clock high");
  a_mosi_hold: assert property (p_mosi_hold) else $error("host data moved at rise");
  a_frame_bits: assert property (p_frame_bits) else $error("frame not whole bytes");
  a_oe_header: assert property (p_oe_header) else $error("data driven inside header");
endmodule // sfp_link_chk
`default_nettype wire

// ===== bench/serial_flash_powerup_frame_test.sv
// Self-checking bench: host and device joined over the serial link
`timescale 1ns/1ps
`default_nettype none
module serial_flash_powerup_frame_test;
  import sfp_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst, mode3, cmd_valid, cmd_program, por_active, frame_ready;
  logic cmd_ready, rsp_valid, access_ok, tx_taken, frame_valid, spi_mode3, standby;
  logic [7:0] cmd_opcode, tx_byte, rsp_data;
  logic [10:0] cmd_page;
  logic [8:0] cmd_offset;
  logic [3:0] cmd_read_len;
  sfp_frame_t frame;
  sfp_frame_t exp_q[$];
  logic [7:0] ops[6] = '{8'hd2, 8'hd4, 8'hd6, 8'h0b, 8'h03, 8'h82};
  int n_mismatch = 0;
  int checked = 0;
  int n_rsp, n_wait, n_acc;
  int cyc = 0;
  sfp_link_if u_sfp_link_if ();
  sfp_host #(.SELECT_DELAY_CYC(20), .PROGRAM_DELAY_CYC(100)) u_sfp_host (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .link(u_sfp_link_if.host), .mode3(mode3),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_opcode(cmd_opcode),
    .cmd_page(cmd_page), .cmd_offset(cmd_offset), .cmd_program(cmd_program),
    .cmd_read_len(cmd_read_len), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .access_ok(access_ok));
  sfp_device u_sfp_device (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .link(u_sfp_link_if.device),
    .por_active(por_active), .tx_byte(tx_byte), .tx_taken(tx_taken),
    .frame_valid(frame_valid), .frame_ready(frame_ready), .frame(frame),
    .spi_mode3(spi_mode3), .standby(standby));
  sfp_link_chk u_sfp_link_chk (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .cs_n(u_sfp_link_if.cs_n),
    .sck(u_sfp_link_if.sck), .mosi(u_sfp_link_if.mosi), .miso_o(u_sfp_link_if.miso_o),
    .miso_oe(u_sfp_link_if.miso_oe), .miso(u_sfp_link_if.miso));

  always #4 sys_clk = ~sys_clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic do_reset();
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
  endtask

  task automatic wait_ready();
    n_wait = 0;
    do begin
      @(negedge sys_clk);
      n_wait++;
    end while (cmd_ready !== 1'b1);
  endtask

  // One command: model frame queued, request held until taken, then run to the end
  task automatic send(input logic [7:0] op, input logic m, input logic prg,
      input logic [3:0] len, input logic push);
    logic [10:0] pg;
    logic [8:0] of;
    pg = 11'($urandom);
    of = 9'($urandom);
    if (push) exp_q.push_back({op, pg, of});
    @(posedge sys_clk);
    mode3 <= m;
    tx_byte <= 8'($urandom);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_opcode <= op;
    cmd_page <= pg;
    cmd_offset <= of;
    cmd_program <= prg;
    cmd_read_len <= len;
    n_rsp = 0;
    wait_ready();
    n_acc = n_wait;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    wait_ready();
    check(n_rsp, len);
    if (push) check(spi_mode3, m);
  endtask

  // Read data model and frame consumer
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      report_and_stop();
    end
    if (tx_taken === 1'b1) tx_byte <= tx_byte + 8'h01;
    if (rsp_valid === 1'b1) begin
      n_rsp++;
      check(rsp_data, 8'(tx_byte - 8'h01));
    end
    if (frame_valid === 1'b1 && frame_ready === 1'b1) begin
      if (exp_q.size() == 0) check(frame_valid, 0);
      else check(frame, exp_q.pop_front());
    end
  end

  initial begin
    void'($urandom(59411));
    sys_rst = 1'b1;
    mode3 = 1'b1;
    cmd_valid = 1'b0;
    cmd_program = 1'b0;
    por_active = 1'b0;
    frame_ready = 1'b1;
    cmd_opcode = 8'h00;
    cmd_page = 11'h000;
    cmd_offset = 9'h000;
    cmd_read_len = 4'h0;
    tx_byte = 8'h00;
    do_reset();
    @(negedge sys_clk);
    check(u_sfp_link_if.miso_oe, 0);
    check(spi_mode3, 1);
    check(access_ok, 0);
    send(8'h82, 1'b1, 1'b1, 4'h0, 1'b1);
    check(n_acc > 90, 1);
    check(standby, 1);
    for (int i = 0; i < 12; i++) begin
      send(ops[i % 6], 1'($urandom), 1'($urandom), 4'($urandom % 3), 1'b1);
    end
    // Stalled consumer: four frames fit, the fifth is refused
    @(posedge sys_clk);
    frame_ready <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      send(8'($urandom), 1'b0, 1'b0, 4'h0, 1'(i < 4));
    end
    @(posedge sys_clk);
    frame_ready <= 1'b1;
    repeat (10) @(posedge sys_clk);
    check(exp_q.size(), 0);
    send(8'h0b, 1'b0, 1'b0, 4'h1, 1'b1);
    do_reset();
    @(negedge sys_clk);
    check(spi_mode3, 1);
    send(8'h03, 1'b1, 1'b0, 4'h2, 1'b1);
    check(n_acc > 14 && n_acc < 30, 1);
    // Reset pulse mid-header: the cut frame must never reach the FIFO
    fork
      send(8'h0b, 1'b0, 1'b0, 4'h0, 1'b0);
      begin
        repeat (200) @(posedge sys_clk);
        por_active <= 1'b1;
        @(posedge sys_clk);
        por_active <= 1'b0;
      end
    join
    @(posedge sys_clk);
    por_active <= 1'b1;
    send(8'hd4, 1'b0, 1'b0, 4'h0, 1'b0);
    check(spi_mode3, 1);
    check(standby, 0);
    @(posedge sys_clk);
    por_active <= 1'b0;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    check(standby, 1);
    report_and_stop();
  end
endmodule // serial_flash_powerup_frame_test
`default_nettype wire
